// ---- shared/rba_pkg.sv ----
// constants of the register bit access bank
package rba_pkg;
	localparam int ADDR_W   = 4;
	localparam int DATA_DEF = 8;
	localparam int NSRC_DEF = 3;

	// source ports in priority order after reset
	localparam int SRC_SPI    = 0;
	localparam int SRC_I2C    = 1;
	localparam int SRC_INBAND = 2;

	// register indices
	localparam logic [ADDR_W-1:0] IDX_RO  = 4'h0;
	localparam logic [ADDR_W-1:0] IDX_RC  = 4'h1;
	localparam logic [ADDR_W-1:0] IDX_WO  = 4'h2;
	localparam logic [ADDR_W-1:0] IDX_W1C = 4'h3;
	localparam logic [ADDR_W-1:0] IDX_LL  = 4'h4;
	localparam logic [ADDR_W-1:0] IDX_LH  = 4'h5;
	localparam logic [ADDR_W-1:0] IDX_SC  = 4'h6;
	localparam logic [ADDR_W-1:0] IDX_CTL = 4'h7;

	// reset values and fixed read values, one bit pattern replicated over the data width
	localparam logic RST_RC  = 1'h0;
	localparam logic RST_WO  = 1'h0;
	localparam logic RST_W1C = 1'h0;
	localparam logic RST_LL  = 1'h1;
	localparam logic RST_LH  = 1'h0;
	localparam logic RST_SC  = 1'h0;
	localparam logic RST_CTL = 1'h0;
	localparam logic RD_WO   = 1'h0;
	localparam logic RD_RSV  = 1'h0;
endpackage

// ---- shared/rba_acc_if.sv ----
// access request bundle between the arbiter and the register bank
`timescale 1ns/1ns
`default_nettype none
interface rba_acc_if #(
	parameter int NSRC = 3,
	parameter int AW   = 4,
	parameter int DW   = 8,
	parameter int SW   = 2
);
	logic [NSRC-1:0]    req;
	logic [NSRC-1:0]    we;
	logic [NSRC*AW-1:0] addr;
	logic [NSRC*DW-1:0] wdata;
	logic [NSRC-1:0]    hold;
	logic               valid;
	logic [SW-1:0]      src;
	logic               acc_we;
	logic [AW-1:0]      acc_addr;
	logic [DW-1:0]      acc_wdata;

	modport arb (
		input  req,
		input  we,
		input  addr,
		input  wdata,
		input  hold,
		output valid,
		output src,
		output acc_we,
		output acc_addr,
		output acc_wdata
	);
	modport bank (
		output req,
		output we,
		output addr,
		output wdata,
		output hold,
		input  valid,
		input  src,
		input  acc_we,
		input  acc_addr,
		input  acc_wdata
	);
endinterface
`default_nettype wire

// ---- hw/rba_arbiter.sv ----
// round robin choice of one access among the host ports
`timescale 1ns/1ns
`default_nettype none
module rba_arbiter #(
	parameter int NSRC = 3,
	parameter int AW   = 4,
	parameter int DW   = 8,
	parameter int SW   = 2
)(
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic ce,
	rba_acc_if.arb    acc
);
	logic [SW-1:0] last_r;
	logic [SW-1:0] last_nxt;
	logic [SW-1:0] pick;
	logic          found;
	int            j;

	generate
		if (NSRC < 1 || SW < 1 || NSRC > (1 << SW)) begin : g_bad
			$error("rba_arbiter: NSRC does not fit SW");
		end
	endgenerate

	// search starts after the last winner so no port starves
	always_comb begin
		found = 1'b0;
		pick = '0;
		j = 0;
		for (int k = 1; k <= NSRC; k++) begin
			j = (int'(last_r) + k) % NSRC;
			if (!found && acc.req[j] && !acc.hold[j]) begin
				found = 1'b1;
				pick = SW'(j);
			end
		end
		acc.valid = found;
		acc.src = pick;
		acc.acc_we = acc.we[pick];
		acc.acc_addr = acc.addr[pick*AW +: AW];
		acc.acc_wdata = acc.wdata[pick*DW +: DW];
		last_nxt = found ? pick : last_r;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			last_r <= SW'(NSRC - 1);
		end else if (ce) begin
			last_r <= last_nxt;
		end
	end
endmodule
`default_nettype wire

// ---- hw/rba_bank.sv ----
// register bank showing each bit access attribute, shared by the host ports
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - the read_only_bit register returns the live status on a read and ignores every write.
// - the read_clear register returns its value on a read, is zeroed after it, and ignores writes.
// - the write_only_bit register takes writes but its read data is undefined and here reads as zero.
// - in the write_one_to_clear register a one written clears that bit and a zero leaves it alone.
// - a latch_low_status bit stays low after its condition went low until a read releases it.
// - a latch_high_status bit stays high after its condition went high until a read releases it.
// - a self_clearing_bit set by software returns to zero once its action is done, zero writes do nothing.
// - the host reaches the whole bank through the serial ports and in-band frames, sharing one path.
module rba_bank #(
	parameter int DATA_W = rba_pkg::DATA_DEF,
	parameter int NSRC   = rba_pkg::NSRC_DEF
)(
	input  wire logic                          mclk,
	input  wire logic                          sys_rst,
	input  wire logic                          ce,
	input  wire logic [NSRC-1:0]               src_req,
	input  wire logic [NSRC-1:0]               src_we,
	input  wire logic [NSRC*rba_pkg::ADDR_W-1:0] src_addr,
	input  wire logic [NSRC*DATA_W-1:0]        src_wdata,
	input  wire logic [DATA_W-1:0]             status_ro,
	input  wire logic [DATA_W-1:0]             event_rc,
	input  wire logic [DATA_W-1:0]             event_w1c,
	input  wire logic [DATA_W-1:0]             cond_ll,
	input  wire logic [DATA_W-1:0]             cond_lh,
	input  wire logic [DATA_W-1:0]             sc_done,
	output logic      [NSRC-1:0]               src_ack,
	output logic      [DATA_W-1:0]             rdata,
	output logic      [DATA_W-1:0]             wo_value,
	output logic      [DATA_W-1:0]             ctl_value,
	output logic      [DATA_W-1:0]             sc_action
);
	localparam int AW = rba_pkg::ADDR_W;
	localparam int SW = (NSRC > 1) ? $clog2(NSRC) : 1;

	generate
		if (DATA_W < 1 || NSRC < 1 || NSRC > (1 << SW)) begin : g_bad
			$error("rba_bank: unsupported DATA_W or NSRC");
		end
	endgenerate

	function automatic logic hit(input logic [AW-1:0] a,
	                             input logic [AW-1:0] idx);
		hit = (a == idx);
	endfunction

	rba_acc_if #(.NSRC(NSRC), .AW(AW), .DW(DATA_W), .SW(SW)) acc ();

	// one path for every host port: spi, i2c and in-band frames
	rba_arbiter #(
		.NSRC (NSRC),
		.AW   (AW),
		.DW   (DATA_W),
		.SW   (SW)
	) u_arb (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.acc     (acc)
	);

	logic [NSRC-1:0]   ack_r;
	logic [NSRC-1:0]   ack_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [DATA_W-1:0] rc_r;
	logic [DATA_W-1:0] rc_nxt;
	logic [DATA_W-1:0] wo_r;
	logic [DATA_W-1:0] wo_nxt;
	logic [DATA_W-1:0] w1c_r;
	logic [DATA_W-1:0] w1c_nxt;
	logic [DATA_W-1:0] ll_r;
	logic [DATA_W-1:0] ll_nxt;
	logic [DATA_W-1:0] lh_r;
	logic [DATA_W-1:0] lh_nxt;
	logic [DATA_W-1:0] sc_r;
	logic [DATA_W-1:0] sc_nxt;
	logic [DATA_W-1:0] ctl_r;
	logic [DATA_W-1:0] ctl_nxt;
	logic              rd;
	logic              wr;
	logic [DATA_W-1:0] wmask;

	// a port whose answer is showing cannot be taken again that cycle
	assign acc.req = src_req;
	assign acc.we = src_we;
	assign acc.addr = src_addr;
	assign acc.wdata = src_wdata;
	assign acc.hold = ack_r;

	assign rd = acc.valid && !acc.acc_we;
	assign wr = acc.valid && acc.acc_we;
	assign wmask = acc.acc_wdata;

	// read data path, values as held before this cycle's side effects
	always_comb begin
		rdata_nxt = rdata_r;
		if (rd) begin
			unique case (acc.acc_addr)
				rba_pkg::IDX_RO:  rdata_nxt = status_ro;
				rba_pkg::IDX_RC:  rdata_nxt = rc_r;
				rba_pkg::IDX_WO:  rdata_nxt = {DATA_W{rba_pkg::RD_WO}};
				rba_pkg::IDX_W1C: rdata_nxt = w1c_r;
				rba_pkg::IDX_LL:  rdata_nxt = ll_r;
				rba_pkg::IDX_LH:  rdata_nxt = lh_r;
				rba_pkg::IDX_SC:  rdata_nxt = sc_r;
				rba_pkg::IDX_CTL: rdata_nxt = ctl_r;
				default:          rdata_nxt = {DATA_W{rba_pkg::RD_RSV}};
			endcase
		end
		ack_nxt = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (acc.valid && acc.src == SW'(i)) begin
				ack_nxt[i] = 1'b1;
			end
		end
	end

	// bit behaviour per attribute; hardware setting wins over clearing
	always_comb begin
		// clears after the read, a new event in that cycle is kept
		if (rd && hit(acc.acc_addr, rba_pkg::IDX_RC)) begin
			rc_nxt = event_rc;
		end else begin
			rc_nxt = rc_r | event_rc;
		end

		wo_nxt = wo_r;
		if (wr && hit(acc.acc_addr, rba_pkg::IDX_WO)) begin
			wo_nxt = wmask;
		end

		if (wr && hit(acc.acc_addr, rba_pkg::IDX_W1C)) begin
			w1c_nxt = (w1c_r & ~wmask) | event_w1c;
		end else begin
			w1c_nxt = w1c_r | event_w1c;
		end

		// a read releases the latch to follow the condition again
		if (rd && hit(acc.acc_addr, rba_pkg::IDX_LL)) begin
			ll_nxt = cond_ll;
		end else begin
			ll_nxt = ll_r & cond_ll;
		end

		if (rd && hit(acc.acc_addr, rba_pkg::IDX_LH)) begin
			lh_nxt = cond_lh;
		end else begin
			lh_nxt = lh_r | cond_lh;
		end

		// software set wins over the done of an earlier action
		if (wr && hit(acc.acc_addr, rba_pkg::IDX_SC)) begin
			sc_nxt = (sc_r & ~sc_done) | wmask;
		end else begin
			sc_nxt = sc_r & ~sc_done;
		end

		ctl_nxt = ctl_r;
		if (wr && hit(acc.acc_addr, rba_pkg::IDX_CTL)) begin
			ctl_nxt = wmask;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ack_r   <= '0;
			rdata_r <= '0;
			rc_r    <= {DATA_W{rba_pkg::RST_RC}};
			wo_r    <= {DATA_W{rba_pkg::RST_WO}};
			w1c_r   <= {DATA_W{rba_pkg::RST_W1C}};
			ll_r    <= {DATA_W{rba_pkg::RST_LL}};
			lh_r    <= {DATA_W{rba_pkg::RST_LH}};
			sc_r    <= {DATA_W{rba_pkg::RST_SC}};
			ctl_r   <= {DATA_W{rba_pkg::RST_CTL}};
		end else if (ce) begin
			ack_r   <= ack_nxt;
			rdata_r <= rdata_nxt;
			rc_r    <= rc_nxt;
			wo_r    <= wo_nxt;
			w1c_r   <= w1c_nxt;
			ll_r    <= ll_nxt;
			lh_r    <= lh_nxt;
			sc_r    <= sc_nxt;
			ctl_r   <= ctl_nxt;
		end
	end

	assign src_ack = ack_r;
	assign rdata = rdata_r;
	assign wo_value = wo_r;
	assign ctl_value = ctl_r;
	assign sc_action = sc_r;
endmodule
`default_nettype wire

// ---- verif/rba_bank_monitor.sv ----
// port assertions of the register bit access bank
`timescale 1ns/1ns
`default_nettype none
module rba_bank_monitor #(
	parameter int DATA_W = 8,
	parameter int NSRC   = 3
)(
	input wire logic                          mclk,
	input wire logic                          sys_rst,
	input wire logic                          ce,
	input wire logic [NSRC-1:0]               src_req,
	input wire logic [NSRC-1:0]               src_we,
	input wire logic [NSRC*rba_pkg::ADDR_W-1:0] src_addr,
	input wire logic [NSRC*DATA_W-1:0]        src_wdata,
	input wire logic [DATA_W-1:0]             status_ro,
	input wire logic [DATA_W-1:0]             sc_done,
	input wire logic [NSRC-1:0]               src_ack,
	input wire logic [DATA_W-1:0]             rdata,
	input wire logic [DATA_W-1:0]             wo_value,
	input wire logic [DATA_W-1:0]             ctl_value,
	input wire logic [DATA_W-1:0]             sc_action
);
	logic              p_we;
	logic              p_ce;
	logic [3:0]        p_a;
	logic [DATA_W-1:0] p_d;
	logic [DATA_W-1:0] p_ro;
	// port 0 request as seen at the taking edge
	always_ff @(posedge mclk) begin
		p_we <= src_we[0];
		p_ce <= ce;
		p_a  <= src_addr[3:0];
		p_d  <= src_wdata[DATA_W-1:0];
		p_ro <= status_ro;
	end
	wire logic rd0 = src_ack[0] & ~p_we & p_ce;
	wire logic wr0 = src_ack[0] & p_we & p_ce;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	chk_ack_cause: assert property (
		$rose(src_ack[0]) |-> $past(src_req[0]) && $past(ce))
		else $error("ack without request");
	chk_ack_pulse: assert property (
		src_ack[0] && ce |=> !src_ack[0]) else $error("ack too long");
	chk_ro_live: assert property (
		rd0 && p_a == rba_pkg::IDX_RO |-> rdata == p_ro)
		else $error("ro read wrong");
	chk_rsv_zero: assert property (
		rd0 && p_a[3] |-> rdata == '0) else $error("reserved read");
	chk_wo_store: assert property (
		wr0 && p_a == rba_pkg::IDX_WO |-> wo_value == p_d)
		else $error("wo not stored");
	chk_ctl_store: assert property (
		wr0 && p_a == rba_pkg::IDX_CTL |-> ctl_value == p_d)
		else $error("ctl not stored");
	chk_ctl_cause: assert property (
		!$past(sys_rst) && $changed(ctl_value) |-> src_ack != '0)
		else $error("ctl changed alone");
	chk_sc_clear: assert property (
		ce && sc_done[0] && !(|(src_req & src_we)) |=> !sc_action[0])
		else $error("sc not cleared");
	chk_sc_hold: assert property (
		ce && sc_done == '0 && sc_action[0] |=> sc_action[0])
		else $error("sc lost");
	chk_ce_freeze: assert property (
		!ce |=> $stable(src_ack) && $stable(rdata) && $stable(ctl_value)
		&& $stable(wo_value) && $stable(sc_action))
		else $error("state moved with ce low");
	cover property (rd0 && p_a == rba_pkg::IDX_RC);
	cover property (wr0 && p_a == rba_pkg::IDX_SC);
	cover property ($rose(src_ack[1]));
	cover property (!ce && src_req[0]);
endmodule
bind rba_bank rba_bank_monitor #(.DATA_W(DATA_W), .NSRC(NSRC))
	rba_bank_monitor_inst (.mclk, .sys_rst, .ce, .src_req, .src_we,
	.src_addr, .src_wdata, .status_ro, .sc_done, .src_ack, .rdata,
	.wo_value, .ctl_value, .sc_action);
`default_nettype wire

// ---- verif/rba_host.sv ----
// host model driving the three access ports
`timescale 1ns/1ns
`default_nettype none
module rba_host (
	input  wire logic [2:0]  src_ack,
	input  wire logic        mclk,
	input  wire logic [7:0]  rdata,
	output var  logic [2:0]  src_req,
	output var  logic [2:0]  src_we,
	output var  logic [11:0] src_addr,
	output var  logic [23:0] src_wdata
);
	initial begin
		src_req   = 3'h0;
		src_we    = 3'h0;
		src_addr  = 12'h000;
		src_wdata = 24'h000000;
	end
	// whole access held until ack is sampled, then released
	task automatic xfer(input int p, input logic w, input logic [3:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge mclk);
		src_req[p]        = 1'b1;
		src_we[p]         = w;
		src_addr[p*4+:4]  = a;
		src_wdata[p*8+:8] = d;
		do @(posedge mclk); while (src_ack[p] !== 1'b1);
		q = rdata;
		@(negedge mclk);
		src_req[p]        = 1'b0;
		src_addr[p*4+:4]  = ~a;
		src_wdata[p*8+:8] = ~d;
	endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench of the register bit access bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        ce = 1'b1;
	logic [7:0]  status_ro = 8'h00, event_rc = 8'h00, event_w1c = 8'h00;
	logic [7:0]  cond_ll = 8'hFF, cond_lh = 8'h00, sc_done = 8'h00;
	logic [2:0]  src_req, src_we, src_ack;
	logic [11:0] src_addr;
	logic [23:0] src_wdata;
	logic [7:0]  rdata, wo_value, ctl_value, sc_action, q;
	int          n_errors = 0, n_tests = 0, cyc = 0;
	always #50 mclk = ~mclk;
	rba_bank rba_bank_inst (.mclk, .sys_rst, .ce, .src_req, .src_we,
		.src_addr, .src_wdata, .status_ro, .event_rc, .event_w1c,
		.cond_ll, .cond_lh, .sc_done, .src_ack, .rdata, .wo_value,
		.ctl_value, .sc_action);
	rba_host rba_host_inst (.mclk, .src_ack, .rdata, .src_req, .src_we,
		.src_addr, .src_wdata);
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rd(logic [3:0] a);
		rba_host_inst.xfer(0, 1'b0, a, 8'h00, q);
	endtask
	task automatic wr(int p, logic [3:0] a, logic [7:0] d);
		logic [7:0] x;
		rba_host_inst.xfer(p, 1'b1, a, d, x);
	endtask
	task automatic pulse(ref logic [7:0] s, input logic [7:0] v, r);
		@(negedge mclk);
		s = v;
		@(negedge mclk);
		s = r;
	endtask
	task t_ro;
		status_ro = 8'hA5;
		wr(1, rba_pkg::IDX_RO, 8'h5A);
		rd(rba_pkg::IDX_RO);
		chk("ro", 8'hA5, q);
	endtask
	task t_rc;
		pulse(event_rc, 8'h81, 8'h00);
		wr(2, rba_pkg::IDX_RC, 8'h7E);
		rd(rba_pkg::IDX_RC);
		chk("rc", 8'h81, q);
		rd(rba_pkg::IDX_RC);
		chk("rc_clr", 8'h00, q);
	endtask
	task t_w1c;
		pulse(event_w1c, 8'hF0, 8'h00);
		wr(1, rba_pkg::IDX_W1C, 8'h30);
		rd(rba_pkg::IDX_W1C);
		chk("w1c", 8'hC0, q);
	endtask
	task t_latch;
		pulse(cond_ll, 8'hFE, 8'hFF);
		rd(rba_pkg::IDX_LL);
		chk("ll", 8'hFE, q);
		rd(rba_pkg::IDX_LL);
		chk("ll_rel", 8'hFF, q);
		pulse(cond_lh, 8'h01, 8'h00);
		rd(rba_pkg::IDX_LH);
		chk("lh", 8'h01, q);
		rd(rba_pkg::IDX_LH);
		chk("lh_rel", 8'h00, q);
	endtask
	task t_sc;
		wr(0, rba_pkg::IDX_SC, 8'h0F);
		chk("sc_set", 8'h0F, sc_action);
		pulse(sc_done, 8'h03, 8'h00);
		wr(0, rba_pkg::IDX_SC, 8'h00);
		rd(rba_pkg::IDX_SC);
		chk("sc", 8'h0C, q);
	endtask
	task t_rsv;
		wr(2, 4'h9, 8'h55);
		rd(4'h9);
		chk("rsv", 8'h00, q);
		wr(0, rba_pkg::IDX_WO, 8'h3C);
		chk("wo", 8'h3C, wo_value);
	endtask
	task t_arb;
		fork
			wr(0, rba_pkg::IDX_CTL, 8'h11);
			wr(1, rba_pkg::IDX_WO, 8'h22);
		join
		rd(rba_pkg::IDX_CTL);
		chk("ctl", 8'h11, q);
		chk("wo_arb", 8'h22, wo_value);
		chk("ctl_out", 8'h11, ctl_value);
	endtask
	// a request waiting while ce is low must not be served
	task t_ce;
		@(negedge mclk);
		ce = 1'b0;
		fork
			wr(0, rba_pkg::IDX_CTL, 8'h33);
			begin
				pulse(event_rc, 8'h04, 8'h00);
				repeat (2) @(negedge mclk);
				chk("ce_ctl", 8'h11, ctl_value);
				ce = 1'b1;
			end
		join
		chk("ctl_ce", 8'h33, ctl_value);
		rd(rba_pkg::IDX_RC);
		chk("rc_ce", 8'h00, q);
	endtask
	// second reset in mid-run brings every output back to its reset value
	task t_rst;
		rd(rba_pkg::IDX_RO);
		@(negedge mclk);
		sys_rst = 1'b1;
		repeat (2) @(negedge mclk);
		sys_rst = 1'b0;
		chk("rst_rdata", 8'h00, rdata);
		chk("rst_ctl", 8'h00, ctl_value);
		chk("rst_wo", 8'h00, wo_value);
		chk("rst_sc", 8'h00, sc_action);
		rd(rba_pkg::IDX_LL);
		chk("rst_ll", 8'hFF, q);
	endtask
	task print_verdict;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			print_verdict;
		end
	end
	initial begin
		repeat (6) @(negedge mclk);
		sys_rst = 1'b0;
		t_ro;
		t_rc;
		t_w1c;
		t_latch;
		t_sc;
		t_rsv;
		t_arb;
		t_ce;
		t_rst;
		print_verdict;
	end
endmodule
`default_nettype wire
